/* File: logic/gpio_atx_watchdog_control.sv */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module gpio_atx_watchdog_control
    import gpio_atx_pkg::*;
#(
    parameter int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ,
    parameter int PWM_STEP_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS)
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire apb_req_type i_apb,
    output apb_rsp_type o_apb,
    input wire logic [NUM_PINS-1:0] i_pin_in,
    output logic [NUM_PINS-1:0] o_pin_out,
    output logic [NUM_PINS-1:0] o_pin_oe,
    output logic [NUM_PINS-1:0][2:0] o_drive_mode,
    input wire logic i_key_confirm,
    input wire logic i_key_cancel,
    input wire misc_status_type i_misc_status,
    output logic o_display_blank,
    output logic o_backlight_off,
    output logic o_reboot
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] drive_of(input logic [2:0] mode, input logic val);
        logic [1:0] r;
        r = 2'b00;
        case (mode)
            MODE_UP_PULLDN: r = {val, val};
            MODE_FAST_BOTH: r = {val, 1'b1};
            MODE_HIZ: r = 2'b00;
            MODE_PULLUP_DN: r = {1'b0, !val};
            MODE_SLOW_UP: r = {val, val};
            MODE_SLOW_BOTH: r = {val, 1'b1};
            MODE_SLOW_DN: r = {1'b0, !val};
            default: r = 2'b00;
        endcase
        return r;
    endfunction : drive_of

    function automatic logic addr_hit(input logic [11:0] a);
        return (a == OFS_CMD) || (a == OFS_ARG) || (a == OFS_REPLY) ||
            (a >= OFS_RDATA0 && a <= OFS_RDATA3 && a[1:0] == 2'b00);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    state_type s_q;
    state_type s_d;

    logic access;
    logic commit;
    logic cmd_wr;
    logic tick;
    logic sec_tick;
    logic pwm_step;
    logic sense;
    logic sense_rise;
    logic wd_fire;
    logic ok;
    logic pwm_val;
    logic [1:0] drv;
    logic [31:0] rd_word;
    logic [7:0] ctype;
    logic [4:0] clen;
    logic [3:0][7:0] d;
    logic [2:0] pidx;
    logic [NUM_PINS-1:0] clr;

    always_comb begin
        s_d = s_q;
        access = i_apb.psel && i_apb.penable;
        commit = access && s_q.apb.pready;
        cmd_wr = commit && i_apb.pwrite && (i_apb.paddr == OFS_CMD);
        ctype = i_apb.pwdata[7:0];
        clen = i_apb.pwdata[12:8];
        d = s_q.arg;
        pidx = d[0][2:0];
        ok = 1'b0;
        clr = '0;
        wd_fire = 1'b0;
        pwm_val = 1'b0;
        drv = 2'b00;
        s_d.reboot = 1'b0;

        // apb read mux; one wait state so prdata comes from a flop
        case (i_apb.paddr)
            OFS_ARG: rd_word = s_q.arg;
            OFS_REPLY: rd_word = {14'h0000, s_q.rnak, s_q.rvalid, s_q.rlen, s_q.rtype};
            default: rd_word = (i_apb.paddr >= OFS_RDATA0 && i_apb.paddr <= OFS_RDATA3) ?
                s_q.reply[4 * i_apb.paddr[3:2] +: 4] : 32'h0000_0000;
        endcase
        if (access && !s_q.apb.pready) begin
            s_d.apb.pready = 1'b1;
            s_d.apb.prdata = i_apb.pwrite ? 32'h0000_0000 : rd_word;
            s_d.apb.pslverr = !addr_hit(i_apb.paddr);
        end else begin
            s_d.apb = '0;
        end
        if (commit && i_apb.pwrite && i_apb.paddr == OFS_ARG) begin
            s_d.arg = i_apb.pwdata;
        end
        if (commit && i_apb.pwrite && i_apb.paddr == OFS_REPLY) begin
            s_d.rvalid = 1'b0;
        end

        tick = s_q.tick_cnt == TICK_CNT_W'(SAMPLE_DIV - 1);
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
        sense = s_q.sample[PIN_SENSE];
        sense_rise = tick && i_pin_in[PIN_SENSE] && !sense;
        if (tick) begin
            s_d.sample = i_pin_in;
        end

        // pwm base: 100 steps per 10 ms
        pwm_step = s_q.pwm_cnt == PWM_CNT_W'(PWM_STEP_DIV - 1);
        s_d.pwm_cnt = pwm_step ? '0 : s_q.pwm_cnt + 1'b1;
        if (pwm_step) begin
            s_d.pwm_phase = (s_q.pwm_phase == 7'(PWM_STEPS - 1)) ? 7'h00 : s_q.pwm_phase + 1'b1;
        end

        sec_tick = tick && s_q.wd_sec == 5'(SEC_TICKS - 1);
        if (tick) begin
            s_d.wd_sec = sec_tick ? 5'h00 : s_q.wd_sec + 1'b1;
        end
        if (s_q.wd_en && sec_tick) begin
            s_d.wd_cnt = s_q.wd_cnt - 1'b1;
            if (s_q.wd_cnt == 8'h01) begin
                wd_fire = 1'b1;
                s_d.wd_en = 1'b0;
            end
        end

        // key hold timer; lock forces a release between pulses
        if (tick) begin
            if (s_q.key_lock) begin
                s_d.key_hold = 8'h00;
                s_d.key_lock = i_key_confirm || i_key_cancel;
            end else if (i_key_confirm || i_key_cancel) begin
                s_d.key_hold = (s_q.key_hold == 8'hff) ? 8'hff : s_q.key_hold + 1'b1;
            end else begin
                s_d.key_hold = 8'h00;
            end
        end

        case (s_q.pstate)
            PS_IDLE: begin
                s_d.pulse_cnt = '0;
                if (wd_fire) begin
                    s_d.pstate = PS_RESET;
                    s_d.keypad_src = 1'b0;
                end else if (s_q.atx_mask[KEY_RST_BIT] && sense && i_key_confirm &&
                        s_q.key_hold >= 8'(HOLD_TICKS)) begin
                    s_d.pstate = PS_RESET;
                    s_d.keypad_src = 1'b1;
                    s_d.key_lock = 1'b1;
                end else if (s_q.atx_mask[KEY_PON_BIT] && !sense && i_key_confirm &&
                        s_q.key_hold >= 8'(TAP_TICKS)) begin
                    s_d.pstate = PS_POWER;
                    s_d.poff_src = 1'b0;
                    s_d.key_lock = 1'b1;
                end else if (s_q.atx_mask[KEY_POFF_BIT] && sense && i_key_cancel &&
                        s_q.key_hold >= 8'(HOLD_TICKS)) begin
                    s_d.pstate = PS_POWER;
                    s_d.poff_src = 1'b1;
                    s_d.key_lock = 1'b1;
                end
            end
            PS_RESET: begin
                if (tick) begin
                    s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
                    if (s_q.pulse_cnt == 9'(RST_TICKS - 1)) begin
                        s_d.pstate = PS_IDLE;
                        s_d.reboot = s_q.keypad_src;
                    end
                end
            end
            PS_POWER: begin
                if (tick) begin
                    s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
                    if (s_q.pulse_cnt == {1'b0, s_q.pulse_len} - 9'h001) begin
                        s_d.pulse_cnt = '0;
                        s_d.pstate = (s_q.poff_src && i_key_cancel) ? PS_EXTEND : PS_IDLE;
                        s_d.reboot = !s_q.poff_src;
                    end
                end
            end
            PS_EXTEND: begin
                if (tick) begin
                    s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
                    if (!i_key_cancel || s_q.pulse_cnt == 9'(EXTEND_TICKS - 1)) begin
                        s_d.pstate = PS_IDLE;
                    end
                end
            end
            default: s_d.pstate = PS_IDLE;
        endcase

        // command execution
        if (cmd_wr) begin
            s_d.rlen = 8'h00;
            case (ctype)
                CMD_STORE_BOOT: begin
                    ok = clen == LEN_ZERO;
                    if (ok) begin
                        s_d.boot_pins = s_q.pins;
                        s_d.boot_atx = s_q.atx_mask;
                        s_d.boot_plen = s_q.pulse_len;
                    end
                end
                CMD_ATX: begin
                    ok = clen == LEN_ONE || (clen == LEN_TWO && d[1] != 8'h00);
                    if (ok) begin
                        s_d.atx_mask = d[0] & ~(8'h01 << WD_ACTIVE_BIT);
                        if (clen == LEN_TWO) begin
                            s_d.pulse_len = d[1];
                        end
                    end
                end
                CMD_WDOG: begin
                    ok = clen == LEN_ONE;
                    if (ok) begin
                        s_d.wd_en = d[0] != 8'h00;
                        s_d.wd_cnt = d[0];
                        s_d.wd_sec = 5'h00;
                    end
                end
                CMD_STATUS: begin
                    ok = clen == LEN_ZERO;
                    if (ok) begin
                        s_d.rlen = STATUS_LEN;
                        s_d.reply = '0;
                        s_d.reply[0] = i_misc_status.fan_report;
                        s_d.reply[4:1] = i_misc_status.temp_report;
                        s_d.reply[5] = i_misc_status.key_press;
                        s_d.reply[6] = i_misc_status.key_release;
                        s_d.reply[7] = s_q.atx_mask | ({7'h00, s_q.wd_en} << WD_ACTIVE_BIT);
                        s_d.reply[8] = s_q.wd_cnt;
                        s_d.reply[12:9] = i_misc_status.glitch_delay;
                        s_d.reply[13] = i_misc_status.contrast;
                        s_d.reply[14] = i_misc_status.backlight;
                    end
                end
                CMD_PIN_SET: begin
                    ok = (clen == LEN_TWO || clen == LEN_THREE) && d[0] < 8'(NUM_PINS) &&
                        d[1] <= LEVEL_HIGH && (clen == LEN_TWO || (d[2] & CFG_RSVD_MASK) == 8'h00);
                    if (ok) begin
                        s_d.pins[pidx].level = d[1];
                        if (clen == LEN_THREE) begin
                            s_d.pins[pidx].func = d[2][CFG_FUNC_BIT];
                            s_d.pins[pidx].mode = d[2][2:0];
                        end
                    end
                end
                CMD_PIN_READ: begin
                    ok = clen == LEN_ONE && d[0] < 8'(NUM_PINS);
                    if (ok) begin
                        s_d.rlen = PIN_READ_LEN;
                        s_d.reply = '0;
                        s_d.reply[0] = d[0];
                        s_d.reply[1] = {5'h00, s_q.rise[pidx], s_q.fall[pidx], s_q.sample[pidx]};
                        s_d.reply[2] = s_q.pins[pidx].level;
                        s_d.reply[3] = {4'h0, s_q.pins[pidx].func, s_q.pins[pidx].mode};
                        clr[pidx] = 1'b1;
                    end
                end
                default: ok = 1'b0;
            endcase
            s_d.rtype = ctype | (ok ? ACK_FLAG : NAK_FLAG);
            s_d.rvalid = 1'b1;
            s_d.rnak = !ok;
        end

        // edge flags: a new edge wins over a query clear
        s_d.rise = (s_q.rise & ~clr) | (tick ? (i_pin_in & ~s_q.sample) : '0);
        s_d.fall = (s_q.fall & ~clr) | (tick ? (~i_pin_in & s_q.sample) : '0);

        s_d.blank = s_q.atx_mask[BLANK_BIT] && !sense;
        if (s_q.blank && sense_rise) begin
            s_d.reboot = 1'b1;
        end

        // reboot restores boot state; the watchdog is left off
        if (s_d.reboot) begin
            s_d.pins = s_q.boot_pins;
            s_d.atx_mask = s_q.boot_atx;
            s_d.pulse_len = s_q.boot_plen;
            s_d.wd_en = 1'b0;
            s_d.wd_cnt = 8'h00;
            s_d.rise = '0;
            s_d.fall = '0;
        end

        // pin drivers
        for (int i = 0; i < NUM_PINS; i++) begin
            pwm_val = {1'b0, s_q.pwm_phase} < s_q.pins[i].level;
            drv = drive_of(s_q.pins[i].mode, pwm_val);
            s_d.pin_out[i] = drv[1];
            s_d.pin_oe[i] = drv[0];
            if (!s_q.pins[i].func) begin
                s_d.pin_out[i] = 1'b0;
                s_d.pin_oe[i] = 1'b0;
                // default power line role, driven only during pulse
                if (i == PIN_POWER) begin
                    s_d.pin_out[i] = s_q.atx_mask[PWR_INV_BIT];
                    s_d.pin_oe[i] = s_q.pstate == PS_POWER || s_q.pstate == PS_EXTEND;
                end
                if (i == PIN_RESET) begin
                    s_d.pin_out[i] = s_q.atx_mask[RST_INV_BIT];
                    s_d.pin_oe[i] = s_q.pstate == PS_RESET;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
            s_q.pins <= BOOT_PINS;
            s_q.boot_pins <= BOOT_PINS;
            s_q.atx_mask <= DEF_ATX_MASK;
            s_q.boot_atx <= DEF_ATX_MASK;
            s_q.pulse_len <= DEF_PULSE_LEN;
            s_q.boot_plen <= DEF_PULSE_LEN;
            s_q.pstate <= PS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign o_apb = s_q.apb;
    assign o_pin_out = s_q.pin_out;
    assign o_pin_oe = s_q.pin_oe;
    assign o_display_blank = s_q.blank;
    assign o_backlight_off = s_q.blank;
    assign o_reboot = s_q.reboot;

    // drive mode to pad strength control
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_mode
        assign o_drive_mode[g] = s_q.pins[g].mode;
    end

endmodule : gpio_atx_watchdog_control

/* File: logic/gpio_atx_pkg.sv */
package gpio_atx_pkg;

    // clock and tick rates
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 32;
    localparam int PWM_HZ = 100;
    localparam int PWM_STEPS = 100;
    localparam int TICK_CNT_W = 24;
    localparam int PWM_CNT_W = 16;

    // times in their own units, converted to 32 Hz ticks
    localparam int KEY_HOLD_S = 4;
    localparam int KEY_TAP_MS = 250;
    localparam int RST_PULSE_S = 1;
    localparam int EXTEND_MAX_S = 5;
    localparam int SEC_TICKS = SAMPLE_HZ;
    localparam int HOLD_TICKS = KEY_HOLD_S * SAMPLE_HZ;
    localparam int TAP_TICKS = (KEY_TAP_MS * SAMPLE_HZ + 999) / 1000;
    localparam int RST_TICKS = RST_PULSE_S * SAMPLE_HZ;
    localparam int EXTEND_TICKS = EXTEND_MAX_S * SAMPLE_HZ;

    // pins
    localparam int NUM_PINS = 5;
    localparam int PIN_SENSE = 1;
    localparam int PIN_POWER = 2;
    localparam int PIN_RESET = 3;
    localparam logic [7:0] LEVEL_HIGH = 8'h64;

    // command codes and reply flags
    localparam logic [7:0] CMD_STORE_BOOT = 8'h04;
    localparam logic [7:0] CMD_ATX = 8'h1c;
    localparam logic [7:0] CMD_WDOG = 8'h1d;
    localparam logic [7:0] CMD_STATUS = 8'h1e;
    localparam logic [7:0] CMD_PIN_SET = 8'h22;
    localparam logic [7:0] CMD_PIN_READ = 8'h23;
    localparam logic [7:0] ACK_FLAG = 8'h40;
    localparam logic [7:0] NAK_FLAG = 8'hc0;
    localparam logic [4:0] LEN_ZERO = 5'h00;
    localparam logic [4:0] LEN_ONE = 5'h01;
    localparam logic [4:0] LEN_TWO = 5'h02;
    localparam logic [4:0] LEN_THREE = 5'h03;
    localparam logic [7:0] STATUS_LEN = 8'h0f;
    localparam logic [7:0] PIN_READ_LEN = 8'h04;

    // power function mask bits
    localparam int RST_INV_BIT = 1;
    localparam int PWR_INV_BIT = 2;
    localparam int WD_ACTIVE_BIT = 3;
    localparam int BLANK_BIT = 4;
    localparam int KEY_RST_BIT = 5;
    localparam int KEY_PON_BIT = 6;
    localparam int KEY_POFF_BIT = 7;

    // configuration byte
    localparam int CFG_FUNC_BIT = 3;
    localparam logic [7:0] CFG_RSVD_MASK = 8'hf0;

    // drive modes
    localparam logic [2:0] MODE_UP_PULLDN = 3'h0;
    localparam logic [2:0] MODE_FAST_BOTH = 3'h1;
    localparam logic [2:0] MODE_HIZ = 3'h2;
    localparam logic [2:0] MODE_PULLUP_DN = 3'h3;
    localparam logic [2:0] MODE_SLOW_UP = 3'h4;
    localparam logic [2:0] MODE_SLOW_BOTH = 3'h5;
    localparam logic [2:0] MODE_RSVD = 3'h6;
    localparam logic [2:0] MODE_SLOW_DN = 3'h7;

    // apb map
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_ARG = 12'h004;
    localparam logic [11:0] OFS_REPLY = 12'h008;
    localparam logic [11:0] OFS_RDATA0 = 12'h010;
    localparam logic [11:0] OFS_RDATA3 = 12'h01c;

    // boot defaults
    localparam logic [7:0] DEF_ATX_MASK = 8'h00;
    localparam logic [7:0] DEF_PULSE_LEN = 8'h20;

    typedef struct packed {
        logic [7:0] level;
        logic func;
        logic [2:0] mode;
    } pin_cfg_type;

    localparam pin_cfg_type [NUM_PINS-1:0] BOOT_PINS = '{
        '{8'h00, 1'b0, MODE_HIZ},
        '{8'h00, 1'b0, MODE_HIZ},
        '{8'h00, 1'b0, MODE_HIZ},
        '{8'h00, 1'b0, MODE_PULLUP_DN},
        '{8'h00, 1'b0, MODE_HIZ}};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic [7:0] fan_report;
        logic [3:0][7:0] temp_report;
        logic [7:0] key_press;
        logic [7:0] key_release;
        logic [3:0][7:0] glitch_delay;
        logic [7:0] contrast;
        logic [7:0] backlight;
    } misc_status_type;

    typedef enum logic [3:0] {
        PS_IDLE = 4'b0001,
        PS_RESET = 4'b0010,
        PS_POWER = 4'b0100,
        PS_EXTEND = 4'b1000
    } pulse_state_type;

    typedef struct packed {
        apb_rsp_type apb;
        logic [31:0] arg;
        logic [7:0] rtype;
        logic [7:0] rlen;
        logic rvalid;
        logic rnak;
        logic [15:0][7:0] reply;
        pin_cfg_type [NUM_PINS-1:0] pins;
        pin_cfg_type [NUM_PINS-1:0] boot_pins;
        logic [7:0] atx_mask;
        logic [7:0] boot_atx;
        logic [7:0] pulse_len;
        logic [7:0] boot_plen;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic [PWM_CNT_W-1:0] pwm_cnt;
        logic [6:0] pwm_phase;
        logic [NUM_PINS-1:0] sample;
        logic [NUM_PINS-1:0] rise;
        logic [NUM_PINS-1:0] fall;
        logic wd_en;
        logic [7:0] wd_cnt;
        logic [4:0] wd_sec;
        pulse_state_type pstate;
        logic [8:0] pulse_cnt;
        logic keypad_src;
        logic poff_src;
        logic [7:0] key_hold;
        logic key_lock;
        logic blank;
        logic reboot;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
    } state_type;

endpackage : gpio_atx_pkg

/* File: verification/gpio_atx_props.sv */
`timescale 1ns/1ns
module gpio_atx_props
    import gpio_atx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire apb_req_type i_apb,
    input wire apb_rsp_type o_apb,
    input wire logic [NUM_PINS-1:0] o_pin_oe,
    input wire logic [NUM_PINS-1:0][2:0] o_drive_mode,
    input wire logic o_display_blank,
    input wire logic o_backlight_off,
    input wire logic o_reboot
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    sequence acc_s;
        i_apb.psel && i_apb.penable && !o_apb.pready;
    endsequence
    blank_pair_a: assert property (o_display_blank == o_backlight_off)
        else $error("blank and backlight differ");
    ready_wait_a: assert property (acc_s |=> o_apb.pready)
        else $error("no ready after access");
    ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("ready held too long");
    ready_cause_a: assert property (o_apb.pready |-> $past(i_apb.psel && i_apb.penable))
        else $error("ready without access");
    bad_addr_a: assert property (acc_s ##0 (i_apb.paddr == 12'h020) |=> o_apb.pslverr)
        else $error("unmapped access not refused");
    reboot_pulse_a: assert property (o_reboot |=> !o_reboot)
        else $error("reboot held too long");
    pulse_hold_a: assert property ($rose(o_pin_oe[3]) |=> o_pin_oe[3] [*8])
        else $error("reset pulse too short");
    boot_mode_a: assert property ($rose(i_arst_n) |-> ##2 o_drive_mode[1] == MODE_PULLUP_DN)
        else $error("boot drive mode wrong");
endmodule : gpio_atx_props
bind gpio_atx_watchdog_control gpio_atx_props props (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(i_apb),
    .o_apb(o_apb), .o_pin_oe(o_pin_oe), .o_drive_mode(o_drive_mode), .o_display_blank(o_display_blank),
    .o_backlight_off(o_backlight_off), .o_reboot(o_reboot));

/* File: verification/host_model.sv */
`timescale 1ns/1ns
module host_model
    import gpio_atx_pkg::*;
(
    input wire logic i_host_on,
    input wire logic [NUM_PINS-1:0] i_pin_out,
    input wire logic [NUM_PINS-1:0] i_pin_oe,
    output logic [NUM_PINS-1:0] o_level
);
    always_comb begin
        // released lines float high on host pull-ups
        o_level = (i_pin_oe & i_pin_out) | ~i_pin_oe;
        o_level[PIN_SENSE] = i_host_on;
    end
endmodule : host_model

/* File: verification/gpio_atx_watchdog_control_tb.sv */
`timescale 1ns/1ns
module gpio_atx_watchdog_control_tb
    import gpio_atx_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic host_on = 1'b1;
    apb_req_type req = '0;
    apb_rsp_type rsp;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe;
    logic [NUM_PINS-1:0][2:0] mode;
    logic blank, bl_off, reboot;
    logic [31:0] rd;
    logic err;
    logic key_ok = 1'b0;
    logic key_no = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int n;
    always #5 clk = ~clk;
    gpio_atx_watchdog_control #(.SAMPLE_DIV(16), .PWM_STEP_DIV(2)) dut (.i_clk(clk), .i_arst_n(arst_n),
        .i_apb(req), .o_apb(rsp), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_drive_mode(mode),
        .i_key_confirm(key_ok), .i_key_cancel(key_no), .i_misc_status('0), .o_display_blank(blank),
        .o_backlight_off(bl_off), .o_reboot(reboot));
    host_model host (.i_host_on(host_on), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_level(pin_in));
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    // bus cycle: one idle cycle after release so the next setup never lands in the same step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        for (n = 0; n < 50 && rsp.pready !== 1'b1; n++) @(posedge clk);
        chk(n < 50, "no ready");
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    task automatic cmd(input logic [7:0] c, input logic [4:0] len, input logic [31:0] arg, input logic nak);
        apb(1'b1, OFS_ARG, arg);
        apb(1'b1, OFS_CMD, {19'h0, len, c});
        apb(1'b0, OFS_REPLY, 32'h0);
        chk({rd[17:16], rd[7:0]} === {nak, 1'b1, c | (nak ? NAK_FLAG : ACK_FLAG)}, "reply");
    endtask : cmd
    task automatic status(input logic [7:0] b7, input logic [7:0] b8);
        cmd(CMD_STATUS, LEN_ZERO, 32'h0, 1'b0);
        chk(rd[15:8] === STATUS_LEN, "status length");
        apb(1'b0, OFS_RDATA0 + 12'h004, 32'h0);
        chk(rd[31:24] === b7, "mask byte");
        apb(1'b0, OFS_RDATA0 + 12'h008, 32'h0);
        chk(rd[7:0] === b8, "counter byte");
    endtask : status
    task automatic t_blank();
        host_on <= 1'b0;
        cmd(CMD_ATX, LEN_ONE, 32'h10, 1'b0);
        for (n = 0; n < 200 && blank !== 1'b1; n++) @(posedge clk);
        chk(blank === 1'b1 && bl_off === 1'b1, "not blanked");
        host_on <= 1'b1;
        for (n = 0; n < 200 && reboot !== 1'b1; n++) @(posedge clk);
        chk(reboot === 1'b1, "no reboot");
        $display("blank test done");
    endtask : t_blank
    task automatic t_pin();
        for (int m = 0; m < 8; m++) begin
            cmd(CMD_PIN_SET, LEN_THREE, {8'h00, 5'h01, m[2:0], 16'h0000}, 1'b0);
            chk(mode[0] === m[2:0], "drive mode");
        end
        cmd(CMD_PIN_SET, LEN_TWO, 32'h0000_6400, 1'b0);
        chk(mode[0] === MODE_SLOW_DN, "value only");
        cmd(CMD_PIN_SET, LEN_TWO, 32'h0000_6500, 1'b1);
        cmd(CMD_PIN_SET, LEN_TWO, 32'h0000_0005, 1'b1);
        cmd(CMD_PIN_SET, LEN_THREE, 32'h0018_0000, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        chk(err === 1'b1, "unmapped read not refused");
        $display("pin test done");
    endtask : t_pin
    task automatic t_wdog();
        cmd(CMD_WDOG, LEN_ONE, 32'h5, 1'b0);
        cmd(CMD_WDOG, LEN_ONE, 32'h0, 1'b0);
        status(8'h00, 8'h00);
        cmd(CMD_ATX, LEN_ONE, 32'h02, 1'b0);
        cmd(CMD_WDOG, LEN_ONE, 32'h1, 1'b0);
        status(8'h0a, 8'h01);
        for (n = 0; n < 1000 && pin_oe[3] !== 1'b1; n++) @(posedge clk);
        chk(pin_oe[3] === 1'b1 && pin_out[3] === 1'b1, "reset pulse");
        for (n = 0; n < 1000 && pin_oe[3] !== 1'b0; n++) @(posedge clk);
        status(8'h02, 8'h00);
        $display("watchdog test done");
    endtask : t_wdog
    // tick is 16 cycles in this bench, so the default pulse spans DEF_PULSE_LEN * 16 cycles
    task automatic t_key();
        host_on <= 1'b0;
        cmd(CMD_ATX, LEN_ONE, 32'h40, 1'b0);
        key_ok <= 1'b1;
        for (n = 0; n < 600 && pin_oe[2] !== 1'b1; n++) @(posedge clk);
        chk(pin_oe[2] === 1'b1 && pin_out[2] === 1'b0, "power pulse");
        key_ok <= 1'b0;
        for (n = 0; n < 1000 && reboot !== 1'b1; n++) @(posedge clk);
        chk(n + 16 >= 16 * DEF_PULSE_LEN && n <= 16 * DEF_PULSE_LEN + 16, "pulse length");
        host_on <= 1'b1;
        repeat (40) @(posedge clk);
        $display("keypad test done");
    endtask : t_key
    task automatic finish_test();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_blank();
        t_pin();
        t_wdog();
        t_key();
        finish_test();
    end
    // whole run needs about 2000 cycles; fifteen times that means a hang
    initial begin
        #300000;
        failures++;
        finish_test();
    end
endmodule : gpio_atx_watchdog_control_tb
